/* File: bcr_bank.sv */
`timescale 1ns/1ns
module bcr_bank
   import bcr_pkg::*;
#(
   parameter logic [7:0] BUILD_NUMBER = 8'h01,
   parameter logic [3:0] TARGET_BOARD_REV = 4'h2,
   parameter logic [7:0] NUM_CFG_REGS = 8'h08,
   // Arbitrary neutral identity values.
   parameter logic [7:0] IMPLEMENTER_CODE = 8'h5a,
   parameter logic [3:0] ARCH_CODE = 4'h7,
   parameter logic [7:0] PART_NUMBER = 8'h3c,
   parameter logic [3:0] RELEASE_VARIANT = 4'h2,
   parameter logic [3:0] RELEASE_REVISION = 4'h0
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [11:0] cfg_addr,
   input wire logic [31:0] cfg_wdata,
   input wire logic cfg_write,
   input wire logic cfg_read,
   output logic [31:0] cfg_rdata,
   output logic cfg_rvalid,
   input wire logic [7:0] switch_pins,
   input wire logic [7:0] lock_pins,
   input wire logic [7:0] lock_mask_pins,
   output logic remap_to_sram,
   output logic [7:0] led_drive,
   output logic txn_start,
   output logic txn_is_write,
   output logic [5:0] txn_function,
   output logic [11:0] txn_device,
   output logic [31:0] txn_outbound,
   input wire logic txn_done,
   input wire logic txn_error,
   input wire logic [31:0] txn_return_in
);

   if (NUM_CFG_REGS == 8'h00)
   begin : g_bad_nreg
      $error("NUM_CFG_REGS must be nonzero");
   end

   // Word match that drops the byte-lane bits of the address.
   function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
      hit = (a[11:WORD_LSB] == off[11:WORD_LSB]);
   endfunction

   bcr_pin_if pins ();

   bcr_pin_sync u_pin_sync (
      .clk(clk),
      .rst(rst),
      .switch_pins(switch_pins),
      .lock_pins(lock_pins),
      .lock_mask_pins(lock_mask_pins),
      .pins(pins)
   );

   logic [3:0] revision;
   logic [31:0] return_data;
   logic txn_busy;
   logic stat_done;
   logic stat_error;
   logic start_req;
   logic finish;
   logic [31:0] next_rdata;

   // A start is only a write of one to bit 31; writing zero there is inert.
   assign start_req = cfg_write && hit(cfg_addr, OFF_TRANSACTION_CONTROL)
      && cfg_wdata[CTRL_START_BIT];
   // Finish events only count while a transaction is outstanding.
   assign finish = txn_busy && (txn_done || txn_error);

   // Remap control; the boot sequence relies on the controller writing one.
   always_ff @(posedge clk)
   begin
      if (rst)
         remap_to_sram <= RESET_REMAP;
      else if (cfg_write && hit(cfg_addr, OFF_MEMORY_REMAP_CONTROL))
         remap_to_sram <= cfg_wdata[REMAP_BIT];
   end

   // LED drive bits, one per LED.
   always_ff @(posedge clk)
   begin
      if (rst)
         led_drive <= RESET_LED;
      else if (cfg_write && hit(cfg_addr, OFF_BOARD_LED_CONTROL))
         led_drive <= cfg_wdata[LED_W-1:0];
   end

   // Board revision, written by the controller at boot.
   always_ff @(posedge clk)
   begin
      if (rst)
         revision <= RESET_REVISION;
      else if (cfg_write && hit(cfg_addr, OFF_BOARD_REVISION))
         revision <= cfg_wdata[REV_W-1:0];
   end

   // Outbound data word for the transaction.
   always_ff @(posedge clk)
   begin
      if (rst)
         txn_outbound <= RESET_WORD;
      else if (cfg_write && hit(cfg_addr, OFF_TRANSACTION_OUTBOUND_DATA))
         txn_outbound <= cfg_wdata;
   end

   // Return data: the servicing party's word on an error-free finish beats a bus write,
   // so a completed read is never overwritten in the same cycle.
   always_ff @(posedge clk)
   begin
      if (rst)
         return_data <= RESET_WORD;
      else if (finish && !txn_error)
         return_data <= txn_return_in;
      else if (cfg_write && hit(cfg_addr, OFF_TRANSACTION_RETURN_DATA))
         return_data <= cfg_wdata;
   end

   // Control fields; reserved bits are simply not stored.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         txn_is_write <= 1'b0;
         txn_function <= 6'h00;
         txn_device <= 12'h000;
      end
      else if (cfg_write && hit(cfg_addr, OFF_TRANSACTION_CONTROL))
      begin
         txn_is_write <= cfg_wdata[CTRL_WRITE_BIT];
         txn_function <= cfg_wdata[CTRL_FUNC_LSB +: CTRL_FUNC_W];
         txn_device <= cfg_wdata[CTRL_DEV_LSB +: CTRL_DEV_W];
      end
   end

   // One-cycle request pulse toward the servicing party.
   always_ff @(posedge clk)
   begin
      if (rst)
         txn_start <= 1'b0;
      else
         txn_start <= start_req;
   end

   // Busy flag reads back as the start bit until the transaction finishes.
   // A new start overrides a finish in the same cycle.
   always_ff @(posedge clk)
   begin
      if (rst)
         txn_busy <= 1'b0;
      else if (start_req)
         txn_busy <= 1'b1;
      else if (finish)
         txn_busy <= 1'b0;
   end

   // Status flags: a finish sets them even in the cycle of a new start,
   // so the outcome of the old transaction is never hidden by the clear.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         stat_done <= 1'b0;
         stat_error <= 1'b0;
      end
      else if (finish)
      begin
         stat_done <= 1'b1;
         stat_error <= (stat_error && !start_req) || txn_error;
      end
      else if (start_req)
      begin
         stat_done <= 1'b0;
         stat_error <= 1'b0;
      end
   end

   // Read multiplexer; unmapped and reserved words return zero.
   always_comb
   begin
      next_rdata = RESET_WORD;
      if (hit(cfg_addr, OFF_MEMORY_REMAP_CONTROL))
         next_rdata[REMAP_BIT] = remap_to_sram;
      else if (hit(cfg_addr, OFF_BOARD_LED_CONTROL))
         next_rdata[LED_W-1:0] = led_drive;
      else if (hit(cfg_addr, OFF_BOARD_SWITCH_STATUS))
         next_rdata[SWITCH_W-1:0] = pins.switches;
      else if (hit(cfg_addr, OFF_BOARD_REVISION))
         next_rdata[REV_W-1:0] = revision;
      else if (hit(cfg_addr, OFF_TRANSACTION_RETURN_DATA))
         next_rdata = return_data;
      else if (hit(cfg_addr, OFF_TRANSACTION_OUTBOUND_DATA))
         next_rdata = txn_outbound;
      else if (hit(cfg_addr, OFF_TRANSACTION_CONTROL))
      begin
         next_rdata[CTRL_START_BIT] = txn_busy;
         next_rdata[CTRL_WRITE_BIT] = txn_is_write;
         next_rdata[CTRL_FUNC_LSB +: CTRL_FUNC_W] = txn_function;
         next_rdata[CTRL_DEV_LSB +: CTRL_DEV_W] = txn_device;
      end
      else if (hit(cfg_addr, OFF_TRANSACTION_STATUS))
      begin
         next_rdata[STAT_DONE_BIT] = stat_done;
         next_rdata[STAT_ERROR_BIT] = stat_error;
      end
      else if (hit(cfg_addr, OFF_CLOCK_LOCK_STATUS))
      begin
         next_rdata[LOCK_MASK_LSB +: LOCK_W] = pins.lock_mask;
         next_rdata[LOCK_STATE_LSB +: LOCK_W] = pins.lock_state;
         next_rdata[LOCK_ALL_BIT] = pins.all_locked;
      end
      else if (hit(cfg_addr, OFF_BUILD_INFORMATION))
      begin
         next_rdata[BUILD_NUM_LSB +: 8] = BUILD_NUMBER;
         next_rdata[BUILD_BOARD_LSB +: 4] = TARGET_BOARD_REV;
         next_rdata[BUILD_NREG_LSB +: 8] = NUM_CFG_REGS;
      end
      else if (hit(cfg_addr, OFF_PERIPHERAL_IDENTITY))
      begin
         next_rdata[ID_IMPL_LSB +: 8] = IMPLEMENTER_CODE;
         next_rdata[ID_VARIANT_LSB +: 4] = RELEASE_VARIANT;
         next_rdata[ID_ARCH_LSB +: 4] = ARCH_CODE;
         next_rdata[ID_PART_LSB +: 8] = PART_NUMBER;
         next_rdata[ID_REV_LSB +: 4] = RELEASE_REVISION;
      end
   end

   // Registered read answer; data holds until the next read is taken.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         cfg_rdata <= RESET_WORD;
         cfg_rvalid <= 1'b0;
      end
      else
      begin
         cfg_rvalid <= cfg_read;
         if (cfg_read)
            cfg_rdata <= next_rdata;
      end
   end

   // Checks on the behaviour above.
   remap_write_a: assert property (@(posedge clk) disable iff (rst)
      cfg_write && hit(cfg_addr, OFF_MEMORY_REMAP_CONTROL)
      |=> remap_to_sram == $past(cfg_wdata[0]))
      else $error("remap bit did not follow write");

   led_write_a: assert property (@(posedge clk) disable iff (rst)
      cfg_write && hit(cfg_addr, OFF_BOARD_LED_CONTROL)
      |=> led_drive == $past(cfg_wdata[7:0]))
      else $error("led drive did not follow write");

   switch_read_a: assert property (@(posedge clk) disable iff (rst)
      cfg_read && hit(cfg_addr, OFF_BOARD_SWITCH_STATUS)
      |=> cfg_rvalid && cfg_rdata == {24'h000000, $past(pins.switches)})
      else $error("switch read wrong");

   rev_store_a: assert property (@(posedge clk) disable iff (rst)
      cfg_write && hit(cfg_addr, OFF_BOARD_REVISION) ##1 !cfg_write
      ##1 cfg_read && hit(cfg_addr, OFF_BOARD_REVISION) && !cfg_write
      |=> cfg_rdata == {28'h0000000, $past(cfg_wdata[3:0], 3)})
      else $error("revision not kept");

   low_bits_a: assert property (@(posedge clk) disable iff (rst)
      cfg_read && cfg_addr[11:2] == 10'h000 && !cfg_write
      |=> cfg_rdata == {31'h00000000, remap_to_sram})
      else $error("low address bits affected decode");

   start_pulse_a: assert property (@(posedge clk) disable iff (rst)
      start_req |=> txn_start ##1 !txn_start || $past(start_req))
      else $error("start pulse wrong");

   ctrl_fields_a: assert property (@(posedge clk) disable iff (rst)
      cfg_write && hit(cfg_addr, OFF_TRANSACTION_CONTROL)
      |=> txn_is_write == $past(cfg_wdata[30])
      && txn_function == $past(cfg_wdata[25:20])
      && txn_device == $past(cfg_wdata[11:0]))
      else $error("control fields not captured");

   lock_read_a: assert property (@(posedge clk) disable iff (rst)
      cfg_read && hit(cfg_addr, OFF_CLOCK_LOCK_STATUS)
      |=> cfg_rdata[15:1] == 15'h0000
      && cfg_rdata[31:24] == $past(pins.lock_mask))
      else $error("lock status read wrong");

   build_read_a: assert property (@(posedge clk) disable iff (rst)
      cfg_read && hit(cfg_addr, OFF_BUILD_INFORMATION)
      |=> cfg_rdata == {BUILD_NUMBER, TARGET_BOARD_REV, 12'h000,
      NUM_CFG_REGS})
      else $error("build information wrong");

   ident_read_a: assert property (@(posedge clk) disable iff (rst)
      cfg_read && hit(cfg_addr, OFF_PERIPHERAL_IDENTITY)
      |=> cfg_rdata[3:0] == RELEASE_REVISION
      && cfg_rdata[23:20] == RELEASE_VARIANT
      && cfg_rdata[31:24] == IMPLEMENTER_CODE
      && cfg_rdata[19:16] == ARCH_CODE
      && cfg_rdata[11:4] == PART_NUMBER
      && cfg_rdata[15:12] == 4'h0)
      else $error("identity wrong");

   status_clear_a: assert property (@(posedge clk) disable iff (rst)
      start_req |=> txn_busy && (stat_done == $past(finish))
      && (stat_error == $past(finish && txn_error)))
      else $error("start did not clear status");

   status_set_a: assert property (@(posedge clk) disable iff (rst)
      finish |=> stat_done && (txn_busy == $past(start_req))
      && (stat_error == (($past(stat_error) && !$past(start_req))
      || $past(txn_error))))
      else $error("finish did not set status");

   reserved_read_a: assert property (@(posedge clk) disable iff (rst)
      cfg_read && hit(cfg_addr, OFF_SPARE_CONFIG_TWO)
      |=> cfg_rdata == 32'h0000_0000)
      else $error("reserved word not zero");

   start_only_a: assert property (@(posedge clk) disable iff (rst)
      !start_req |=> !txn_start)
      else $error("start pulse without a start write");

   read_answer_a: assert property (@(posedge clk) disable iff (rst)
      cfg_rvalid == $past(cfg_read))
      else $error("read answer timing wrong");

endmodule

/* File: bcr_pkg.sv */
package bcr_pkg;

   // Register access port geometry.
   localparam int ADDR_W = 12;
   localparam int DATA_W = 32;
   localparam int WORD_LSB = 2;

   // Register byte offsets; address bits 1 and 0 are never decoded.
   localparam logic [11:0] OFF_MEMORY_REMAP_CONTROL = 12'h000;
   localparam logic [11:0] OFF_BOARD_LED_CONTROL = 12'h004;
   localparam logic [11:0] OFF_SPARE_CONFIG_TWO = 12'h008;
   localparam logic [11:0] OFF_BOARD_SWITCH_STATUS = 12'h00c;
   localparam logic [11:0] OFF_BOARD_REVISION = 12'h010;
   localparam logic [11:0] OFF_SPARE_CONFIG_FIVE = 12'h014;
   localparam logic [11:0] OFF_SPARE_CONFIG_SIX = 12'h018;
   localparam logic [11:0] OFF_SPARE_CONFIG_SEVEN = 12'h01c;
   localparam logic [11:0] OFF_TRANSACTION_RETURN_DATA = 12'h0a0;
   localparam logic [11:0] OFF_TRANSACTION_OUTBOUND_DATA = 12'h0a4;
   localparam logic [11:0] OFF_TRANSACTION_CONTROL = 12'h0a8;
   localparam logic [11:0] OFF_TRANSACTION_STATUS = 12'h0ac;
   localparam logic [11:0] OFF_CLOCK_LOCK_STATUS = 12'h100;
   localparam logic [11:0] OFF_BUILD_INFORMATION = 12'hff8;
   localparam logic [11:0] OFF_PERIPHERAL_IDENTITY = 12'hffc;

   // Field positions and widths.
   localparam int REMAP_BIT = 0;
   localparam int LED_W = 8;
   localparam int SWITCH_W = 8;
   localparam int REV_W = 4;
   localparam int CTRL_START_BIT = 31;
   localparam int CTRL_WRITE_BIT = 30;
   localparam int CTRL_FUNC_LSB = 20;
   localparam int CTRL_FUNC_W = 6;
   localparam int CTRL_DEV_LSB = 0;
   localparam int CTRL_DEV_W = 12;
   localparam int STAT_DONE_BIT = 0;
   localparam int STAT_ERROR_BIT = 1;
   localparam int LOCK_W = 8;
   localparam int LOCK_MASK_LSB = 24;
   localparam int LOCK_STATE_LSB = 16;
   localparam int LOCK_ALL_BIT = 0;
   localparam int BUILD_NUM_LSB = 24;
   localparam int BUILD_BOARD_LSB = 20;
   localparam int BUILD_NREG_LSB = 0;
   localparam int ID_IMPL_LSB = 24;
   localparam int ID_VARIANT_LSB = 20;
   localparam int ID_ARCH_LSB = 16;
   localparam int ID_PART_LSB = 4;
   localparam int ID_REV_LSB = 0;

   // Values after reset.
   localparam logic RESET_REMAP = 1'b0;
   localparam logic [7:0] RESET_LED = 8'h00;
   localparam logic [3:0] RESET_REVISION = 4'h0;
   localparam logic [31:0] RESET_WORD = 32'h0000_0000;

   // Cycle counts.
   localparam int SYNC_STAGES = 2;
   localparam int READ_LATENCY = 1;

endpackage

/* File: bcr_pin_if.sv */
`timescale 1ns/1ns
// Synchronised board-pin state handed from the pin stage to the bank.
interface bcr_pin_if;
   logic [7:0] switches;
   logic [7:0] lock_state;
   logic [7:0] lock_mask;
   logic all_locked;
   modport stage (output switches, output lock_state, output lock_mask,
      output all_locked);
   modport bank (input switches, input lock_state, input lock_mask,
      input all_locked);
endinterface

/* File: bcr_pin_sync.sv */
`timescale 1ns/1ns
// Two-flop synchronisers for the switch, lock and lock-mask pins.
module bcr_pin_sync
   import bcr_pkg::*;
(
   input wire logic clk,
   input wire logic rst,
   input wire logic [7:0] switch_pins,
   input wire logic [7:0] lock_pins,
   input wire logic [7:0] lock_mask_pins,
   bcr_pin_if.stage pins
);

   logic [7:0] sw_meta;
   logic [7:0] lock_meta;
   logic [7:0] mask_meta;

   // First stage only feeds the second stage; nothing else looks at it.
   always_ff @(posedge clk)
   begin
      if (rst)
      begin
         sw_meta <= 8'h00;
         lock_meta <= 8'h00;
         mask_meta <= 8'h00;
         pins.switches <= 8'h00;
         pins.lock_state <= 8'h00;
         pins.lock_mask <= 8'h00;
      end
      else
      begin
         sw_meta <= switch_pins;
         lock_meta <= lock_pins;
         mask_meta <= lock_mask_pins;
         pins.switches <= sw_meta;
         pins.lock_state <= lock_meta;
         pins.lock_mask <= mask_meta;
      end
   end

   // A masked loop counts as locked so a disabled loop never holds it low.
   always_ff @(posedge clk)
   begin
      if (rst)
         pins.all_locked <= 1'b0;
      else
         pins.all_locked <= &(pins.lock_state | pins.lock_mask);
   end

endmodule

/* File: bcr_service_model.sv */
`timescale 1ns/1ns
// Behavioural stand-in for the party that services configuration
// transactions. It answers each start seen while idle after a delay set by the bench.
// It fails a transaction only when the bench asks it to.
module bcr_service_model
(
   input wire logic clk,
   input wire logic rst,
   input wire logic txn_start,
   input wire logic [3:0] delay,
   input wire logic fail,
   input wire logic [31:0] word,
   output logic txn_done,
   output logic txn_error,
   output logic [31:0] txn_return_in
);
   // Between answers the return bus walks, so a stale word cannot pass.
   // A start that arrives while an answer is pending is not seen here.
   initial
   begin
      txn_done = 1'b0;
      txn_error = 1'b0;
      txn_return_in = 32'h0000_0001;
      forever
      begin
         @(posedge clk);
         if (!rst && txn_start === 1'b1)
         begin
            repeat (delay) @(posedge clk);
            @(negedge clk);
            txn_done = !fail;
            txn_error = fail;
            txn_return_in = word;
            @(negedge clk);
            txn_done = 1'b0;
            txn_error = 1'b0;
         end
         else
         begin
            @(negedge clk);
            txn_return_in = {txn_return_in[30:0], ~txn_return_in[31]};
         end
      end
   end
endmodule

/* File: bcr_bank_test.sv */
`timescale 1ns/1ns
`define CHK(nm, e, g) \
   begin \
      comparisons++; \
      if ((g) !== (e)) \
      begin \
         fails++; \
         $display("MISMATCH %s exp %h got %h", nm, e, g); \
      end \
   end

module bcr_bank_test
   import bcr_pkg::*;
;
   // Identity and build values are arbitrary; the release is r1p0.
   localparam logic [7:0] T_IMPL = 8'h6b;
   localparam logic [3:0] T_ARCH = 4'h3;
   localparam logic [7:0] T_PART = 8'h9d;
   localparam logic [7:0] T_BUILD = 8'h17;
   localparam logic [3:0] T_BOARD = 4'h2;
   localparam logic [7:0] T_NREG = 8'h08;
   logic clk, rst, cfg_write, cfg_read, cfg_rvalid, remap_to_sram;
   logic [11:0] cfg_addr, txn_device;
   logic [31:0] cfg_wdata, cfg_rdata, txn_outbound, txn_return_in;
   logic [7:0] switch_pins, lock_pins, lock_mask_pins, led_drive;
   logic txn_start, txn_is_write, txn_done, txn_error, svc_fail;
   logic [5:0] txn_function;
   logic [3:0] svc_delay;
   logic [31:0] svc_word;
   logic [31:0] seed = 32'he2a1;
   int fails = 0;
   int comparisons = 0;

   bcr_bank #(.BUILD_NUMBER(T_BUILD), .TARGET_BOARD_REV(T_BOARD),
      .NUM_CFG_REGS(T_NREG), .IMPLEMENTER_CODE(T_IMPL), .ARCH_CODE(T_ARCH),
      .PART_NUMBER(T_PART), .RELEASE_VARIANT(4'h1),
      .RELEASE_REVISION(4'h0)) i_dut (.clk(clk), .rst(rst),
      .cfg_addr(cfg_addr), .cfg_wdata(cfg_wdata), .cfg_write(cfg_write),
      .cfg_read(cfg_read), .cfg_rdata(cfg_rdata), .cfg_rvalid(cfg_rvalid),
      .switch_pins(switch_pins), .lock_pins(lock_pins),
      .lock_mask_pins(lock_mask_pins), .remap_to_sram(remap_to_sram),
      .led_drive(led_drive), .txn_start(txn_start),
      .txn_is_write(txn_is_write), .txn_function(txn_function),
      .txn_device(txn_device), .txn_outbound(txn_outbound),
      .txn_done(txn_done), .txn_error(txn_error),
      .txn_return_in(txn_return_in));

   bcr_service_model i_svc (.clk(clk), .rst(rst), .txn_start(txn_start),
      .delay(svc_delay), .fail(svc_fail), .word(svc_word),
      .txn_done(txn_done), .txn_error(txn_error),
      .txn_return_in(txn_return_in));

   // Free-running 10 MHz clock.
   initial
   begin
      clk = 1'b0;
      forever #50 clk = ~clk;
   end

   // Xorshift source, so every run sees the same stimulus.
   function automatic logic [31:0] rnd();
      seed = seed ^ (seed << 13);
      seed = seed ^ (seed >> 17);
      seed = seed ^ (seed << 5);
      return seed;
   endfunction

   // Expected lock word: all-locked counts a masked loop as locked.
   function automatic logic [31:0] exp_lock(logic [7:0] m, logic [7:0] l);
      return {m, l, 15'h0000, &(l | m)};
   endfunction

   // Expected control word; reserved bits read zero, bit 31 is busy.
   function automatic logic [31:0] exp_ctrl(logic busy, logic [31:0] w);
      return {busy, w[30], 4'h0, w[25:20], 8'h00, w[11:0]};
   endfunction

   task automatic print_verdict;
      if (fails == 0 && comparisons > 0)
         $display("Finished cleanly");
      else
         $display("Finished with errors");
      $finish;
   endtask

   // One write: held for one rising edge, effects visible on return.
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(negedge clk);
      cfg_addr = a;
      cfg_wdata = d;
      cfg_write = 1'b1;
      @(negedge clk);
      cfg_write = 1'b0;
      cfg_wdata = ~d;
   endtask

   // One read; the answer is checked in the cycle after the request.
   task automatic rd(input logic [11:0] a, input logic [31:0] e,
      input string nm);
      @(negedge clk);
      cfg_addr = a;
      cfg_read = 1'b1;
      @(negedge clk);
      cfg_read = 1'b0;
      `CHK("rvalid", 1'b1, cfg_rvalid)
      `CHK(nm, e, cfg_rdata)
   endtask

   // The hang guard allows over fifteen times the expected run length.
   initial
   begin
      repeat (6000) @(posedge clk);
      fails++;
      print_verdict();
   end

   initial
   begin
      logic [31:0] w, ret;
      logic [11:0] zl [9];
      int d;
      zl = '{12'h008, 12'h00c, 12'h014, 12'h01c, 12'h020, 12'h0ac,
         12'h104, 12'h0fc, 12'hff4};
      rst = 1'b1;
      cfg_addr = 12'h000;
      cfg_wdata = 32'h0000_0000;
      cfg_write = 1'b0;
      cfg_read = 1'b0;
      switch_pins = 8'h00;
      lock_pins = 8'h00;
      lock_mask_pins = 8'h00;
      svc_delay = 4'h0;
      svc_fail = 1'b0;
      svc_word = 32'h0000_0000;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      // Writable registers come up clear and the outputs idle.
      `CHK("remap", 1'b0, remap_to_sram)
      `CHK("leds", 8'h00, led_drive)
      rd(OFF_MEMORY_REMAP_CONTROL, 32'h0, "remap reset");
      rd(OFF_TRANSACTION_CONTROL, 32'h0, "ctrl reset");
      // Identity and build words are fixed; writes must not touch them.
      wr(OFF_PERIPHERAL_IDENTITY, rnd());
      rd(OFF_PERIPHERAL_IDENTITY, {T_IMPL, 4'h1, T_ARCH, 4'h0, T_PART,
         4'h0}, "identity");
      wr(OFF_BUILD_INFORMATION, rnd());
      rd(OFF_BUILD_INFORMATION, {T_BUILD, T_BOARD, 12'h000, T_NREG},
         "build");
      // Reserved and read-only places read zero before and after writes.
      for (int j = 0; j < 9; j++)
      begin
         rd(zl[j], 32'h0, "zero place");
         wr(zl[j], rnd());
         rd(zl[j], 32'h0, "zero place written");
      end
      // Boot order: revision first, then remap on, with stray low bits.
      w = rnd();
      wr(OFF_BOARD_REVISION, w);
      rd(OFF_BOARD_REVISION | 12'h3, {28'h0, w[3:0]}, "revision");
      wr(OFF_MEMORY_REMAP_CONTROL | 12'h2, 32'h0000_0001);
      `CHK("remap on", 1'b1, remap_to_sram)
      rd(OFF_MEMORY_REMAP_CONTROL | 12'h1, 32'h1, "remap on word");
      wr(OFF_MEMORY_REMAP_CONTROL, 32'hffff_fffe);
      `CHK("remap off", 1'b0, remap_to_sram)
      rd(OFF_MEMORY_REMAP_CONTROL, 32'h0, "remap word");
      // LEDs and pin readback with random data and address low bits.
      for (int i = 0; i < 8; i++)
      begin
         w = rnd();
         wr({OFF_BOARD_LED_CONTROL[11:2], w[9:8]}, w);
         `CHK("leds", w[7:0], led_drive)
         rd(OFF_BOARD_LED_CONTROL, {24'h0, w[7:0]}, "led word");
         @(negedge clk);
         switch_pins = w[31:24];
         lock_mask_pins = (i == 3) ? 8'hff : w[23:16];
         lock_pins = (i > 4) ? ~lock_mask_pins : w[15:8];
         repeat (4) @(negedge clk);
         rd(OFF_BOARD_SWITCH_STATUS, {24'h0, switch_pins}, "switch");
         rd(OFF_CLOCK_LOCK_STATUS, exp_lock(lock_mask_pins, lock_pins),
            "lock");
      end
      // Data words of the mailbox are plain read-write storage.
      w = rnd();
      wr(OFF_TRANSACTION_OUTBOUND_DATA, w);
      `CHK("outbound", w, txn_outbound)
      rd(OFF_TRANSACTION_OUTBOUND_DATA, w, "outbound word");
      ret = rnd();
      wr(OFF_TRANSACTION_RETURN_DATA, ret);
      rd(OFF_TRANSACTION_RETURN_DATA, ret, "return word");
      // A control write without the start bit only updates the fields.
      w = rnd() & 32'h7fff_ffff;
      wr(OFF_TRANSACTION_CONTROL, w);
      `CHK("no start", 1'b0, txn_start)
      `CHK("fields", {w[30], w[25:20], w[11:0]}, {txn_is_write,
         txn_function, txn_device})
      // Transactions to devices 0, 1 and 2, prompt and slow, one failing.
      for (int i = 0; i < 6; i++)
      begin
         d = i * 2;
         svc_delay = d[3:0];
         svc_fail = (i == 4);
         svc_word = rnd();
         w = rnd() | 32'h8000_0000;
         w[11:0] = 12'(i % 3);
         wr(OFF_TRANSACTION_CONTROL, w);
         `CHK("start", 1'b1, txn_start)
         `CHK("fields", {w[30], w[25:20], w[11:0]}, {txn_is_write,
            txn_function, txn_device})
         rd(OFF_TRANSACTION_CONTROL, exp_ctrl(1'b1, w), "busy");
         `CHK("start gone", 1'b0, txn_start)
         if (d > 1)
            rd(OFF_TRANSACTION_STATUS, 32'h0, "status cleared");
         repeat (14) @(negedge clk);
         rd(OFF_TRANSACTION_STATUS, {30'h0, svc_fail, 1'b1},
            "status");
         if (!svc_fail)
            ret = svc_word;
         rd(OFF_TRANSACTION_RETURN_DATA, ret, "returned");
         rd(OFF_TRANSACTION_CONTROL, exp_ctrl(1'b0, w), "idle");
      end
      // A second reset returns every register and output to idle.
      @(negedge clk);
      rst = 1'b1;
      repeat (2) @(negedge clk);
      rst = 1'b0;
      `CHK("remap reset", 1'b0, remap_to_sram)
      `CHK("leds reset", 8'h00, led_drive)
      `CHK("outbound reset", 32'h0, txn_outbound)
      rd(OFF_TRANSACTION_CONTROL, 32'h0, "ctrl after reset");
      rd(OFF_TRANSACTION_STATUS, 32'h0, "status reset");
      rd(OFF_BOARD_REVISION, 32'h0, "revision reset");
      print_verdict();
   end
endmodule
